// file: prog_byte_ram.sv
// Simple dual-port byte memory with a registered read port.
`timescale 1ns/1ps
module prog_byte_ram #(
  parameter int ADDR_W = 8,
  parameter int DATA_W = 8
) (
  input wire logic clk_sys,
  input wire logic we,
  input wire logic [ADDR_W-1:0] waddr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic [ADDR_W-1:0] raddr,
  output logic [DATA_W-1:0] rdata_q
);

  logic [DATA_W-1:0] mem [2**ADDR_W];

  // Contents are undefined after power-up until written; a chip erase walks over the flash and EEPROM instances only, not the page buffer.
  always_ff @(posedge clk_sys) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata_q <= mem[raddr];
  end

endmodule

// file: spi_prog_core.sv
// Device-side serial programming engine: link shifter, decoder and memory writer.
`timescale 1ns/1ps
module spi_prog_core #(
  parameter int FLASH_BYTE_W = 13,
  parameter int EEP_ADDR_W = 9,
  parameter int CNT_W = 21,
  parameter int FLASH_WAIT_CYC = spi_prog_pkg::FLASH_WRITE_WAIT_CYC,
  parameter int EEP_WAIT_CYC = spi_prog_pkg::EEPROM_WRITE_WAIT_CYC,
  parameter int ERASE_WAIT_CYC = spi_prog_pkg::ERASE_WAIT_CYC
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic prog_reset_n,
  input wire logic sck,
  input wire logic mosi,
  output logic miso,
  output logic miso_oe,
  output logic prog_enabled,
  output logic ready_busy_flag
);
  import spi_prog_pkg::*;

  localparam int BUF_W = PAGE_WORD_W + 1;
  localparam int PAGE_W = FLASH_BYTE_W - BUF_W;
  localparam logic [FLASH_BYTE_W-1:0] FLASH_LAST = FLASH_BYTE_W'(2**FLASH_BYTE_W - 1);
  localparam logic [FLASH_BYTE_W-1:0] COPY_LAST = FLASH_BYTE_W'(2**BUF_W);
  localparam logic [FLASH_BYTE_W-1:0] EEP_PG_LAST = FLASH_BYTE_W'(2**EEP_PAGE_W - 1);
  localparam logic [FLASH_BYTE_W-1:0] EEP_BYTES = FLASH_BYTE_W'(2**EEP_ADDR_W);

  // Pin synchronisers: a level counts once the second and third stages agree.
  logic [2:0] pin_raw;
  logic [2:0] s1_q;
  logic [2:0] s2_q;
  logic [2:0] s3_q;
  logic [2:0] filt_q;
  logic sck_prev_q;

  assign pin_raw = {prog_reset_n, sck, mosi};

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      s1_q <= PIN_FILT_RESET;
      s2_q <= PIN_FILT_RESET;
      s3_q <= PIN_FILT_RESET;
    end else begin
      s1_q <= pin_raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  generate
    for (genvar i = 0; i < 3; i++) begin : g_filt
      always_ff @(posedge clk_sys) begin
        if (!nrst) begin
          filt_q[i] <= PIN_FILT_RESET[i];
        end else if (s2_q[i] == s3_q[i]) begin
          filt_q[i] <= s3_q[i];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      sck_prev_q <= 1'b0;
    end else begin
      sck_prev_q <= filt_q[1];
    end
  end

  wire mosi_f = filt_q[0];
  wire prog_mode = ~filt_q[2];
  // Edges are only seen reliably because each clock phase outlasts the filter delay.
  wire sck_rise = filt_q[1] & ~sck_prev_q;
  wire sck_fall = ~filt_q[1] & sck_prev_q;

  // Link shifter state.
  logic [4:0] bit_q;
  logic [31:0] rx_q;
  logic [7:0] tx_q;
  logic miso_q;
  logic en_q;
  logic [1:0] rd_stage_q;

  // Engine state.
  state_t state_q;
  op_t op_q;
  logic [FLASH_BYTE_W-1:0] walk_q;
  logic [CNT_W-1:0] cnt_q;
  logic [PAGE_W-1:0] page_q;
  logic [EEP_ADDR_W-1:0] eaddr_q;
  logic [5:0] lock_q;
  logic [7:0] epbuf_q [2**EEP_PAGE_W];
  logic [2**EEP_PAGE_W-1:0] epmask_q;

  // Completed instruction and its decode.
  wire [31:0] word_now = {rx_q[30:0], mosi_f};
  instr_t w;
  assign w = word_now;
  cmd_t xcmd;
  assign xcmd = decode_cmd(w.b1, w.b2);
  wire done = prog_mode & sck_rise & (bit_q == BIT_LAST);
  wire busy = (state_q != ST_IDLE);
  // Every write, load and erase waits for enable and an idle engine; reads and polls do not.
  wire act = done & en_q & ~busy;

  wire start_erase = act & (xcmd == CMD_ERASE);
  wire start_flash = act & (xcmd == CMD_FLASH_WR);
  wire start_eep_byte = act & (xcmd == CMD_EEP_WR);
  wire start_eep_page = act & (xcmd == CMD_EEP_PG);
  wire load_flash = act & (xcmd == CMD_FLASH_LD);
  wire load_eep = act & (xcmd == CMD_EEP_LD);
  wire write_lock = act & (xcmd == CMD_LOCK_WR);

  wire [7:0] pg_field = {w.b2[5:0], w.b3[7:6]};
  wire [9:0] w_eaddr_full = {w.b2[1:0], w.b3};
  wire [EEP_ADDR_W-1:0] w_eaddr = w_eaddr_full[EEP_ADDR_W-1:0];

  // Read-side view: during byte 4 the first three bytes sit in rx_q[23:0].
  instr_t rdi;
  assign rdi = {rx_q[23:0], 8'h00};
  cmd_t rcmd;
  assign rcmd = decode_cmd(rdi.b1, rdi.b2);
  wire [13:0] flash_rd_full = {rdi.b2[4:0], rdi.b3, rdi.b1[3]};
  wire [FLASH_BYTE_W-1:0] flash_raddr = flash_rd_full[FLASH_BYTE_W-1:0];
  wire [9:0] eep_rd_full = {rdi.b2[1:0], rdi.b3};
  wire [EEP_ADDR_W-1:0] eep_raddr = eep_rd_full[EEP_ADDR_W-1:0];

  // Memories.
  logic [7:0] flash_rdata;
  logic [7:0] eep_rdata;
  logic [7:0] buf_rdata;
  wire walking = (state_q == ST_WALK);
  wire [FLASH_BYTE_W-1:0] walk_dec = walk_q - FLASH_BYTE_W'(1);
  wire [EEP_PAGE_W-1:0] walk_lo = walk_q[EEP_PAGE_W-1:0];

  wire fl_we = walking & ((op_q == OP_ERASE) | ((op_q == OP_FLASH) & (walk_q != '0)));
  // Buffer read lags one cycle, so flash byte k-1 is written while k is read.
  wire [FLASH_BYTE_W-1:0] fl_waddr = (op_q == OP_ERASE) ? walk_q :
                                     {page_q, walk_dec[BUF_W-1:0]};
  wire [7:0] fl_wdata = (op_q == OP_ERASE) ? ERASED_BYTE : buf_rdata;

  wire buf_we = load_flash;
  // Word index from six address bits, half select picks the byte.
  wire [BUF_W-1:0] buf_waddr = {w.b3[PAGE_WORD_W-1:0], w.b1[3]};

  wire ee_erase_we = walking & (op_q == OP_ERASE) & (walk_q < EEP_BYTES);
  wire ee_page_we = walking & (op_q == OP_EEP_PAGE) & epmask_q[walk_lo];
  // A byte write simply overwrites, so the location needs no separate erase.
  wire ee_we = start_eep_byte | ee_erase_we | ee_page_we;
  wire [EEP_ADDR_W-1:0] ee_waddr = start_eep_byte ? w_eaddr :
                                   ee_erase_we ? walk_q[EEP_ADDR_W-1:0] :
                                   {eaddr_q[EEP_ADDR_W-1:EEP_PAGE_W], walk_lo};
  wire [7:0] ee_wdata = start_eep_byte ? w.b4 :
                        ee_erase_we ? ERASED_BYTE : epbuf_q[walk_lo];

  prog_byte_ram #(.ADDR_W(FLASH_BYTE_W), .DATA_W(8)) u_flash (
    .clk_sys(clk_sys),
    .we(fl_we),
    .waddr(fl_waddr),
    .wdata(fl_wdata),
    .raddr(flash_raddr),
    .rdata_q(flash_rdata)
  );

  prog_byte_ram #(.ADDR_W(EEP_ADDR_W), .DATA_W(8)) u_eeprom (
    .clk_sys(clk_sys),
    .we(ee_we),
    .waddr(ee_waddr),
    .wdata(ee_wdata),
    .raddr(eep_raddr),
    .rdata_q(eep_rdata)
  );

  prog_byte_ram #(.ADDR_W(BUF_W), .DATA_W(8)) u_page_buf (
    .clk_sys(clk_sys),
    .we(buf_we),
    .waddr(buf_waddr),
    .wdata(w.b4),
    .raddr(walk_q[BUF_W-1:0]),
    .rdata_q(buf_rdata)
  );

  // Read answer selection; locations under programming read as all ones.
  wire flash_hidden = busy & ((op_q == OP_ERASE) |
                      ((op_q == OP_FLASH) &
                       (flash_raddr[FLASH_BYTE_W-1:BUF_W] == page_q)));
  wire eep_hidden = busy & ((op_q == OP_ERASE) |
                    ((op_q == OP_EEP_BYTE) & (eep_raddr == eaddr_q)) |
                    ((op_q == OP_EEP_PAGE) &
                     (eep_raddr[EEP_ADDR_W-1:EEP_PAGE_W] ==
                      eaddr_q[EEP_ADDR_W-1:EEP_PAGE_W])));
  wire [7:0] rd_val = (rcmd == CMD_POLL) ? {7'h00, busy} :
                      (rcmd == CMD_LOCK_RD) ? {LOCK_READ_PAD, lock_q} :
                      (rcmd == CMD_FLASH_RD) ? (flash_hidden ? ERASED_BYTE : flash_rdata) :
                      (rcmd == CMD_EEP_RD) ? (eep_hidden ? ERASED_BYTE : eep_rdata) :
                      8'h00;

  // Link shifter. Releasing the reset pin drops sync, so a reset pulse resyncs.
  always_ff @(posedge clk_sys) begin
    if (!nrst || !prog_mode) begin
      bit_q <= 5'h00;
      rx_q <= 32'h0000_0000;
      tx_q <= 8'h00;
      miso_q <= 1'b0;
      rd_stage_q <= 2'h0;
    end else begin
      rd_stage_q <= {rd_stage_q[0], sck_rise & (bit_q == BIT_ADDR)};
      if (sck_rise) begin
        rx_q <= word_now;
        bit_q <= bit_q + 5'h01;
        if (bit_q == BIT_ECHO) begin
          tx_q <= word_now[7:0];
        end
      end else if (rd_stage_q[1]) begin
        tx_q <= rd_val;
      end else if (sck_fall) begin
        miso_q <= tx_q[7];
        tx_q <= {tx_q[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst || !prog_mode) begin
      en_q <= 1'b0;
    end else if (done && xcmd == CMD_ENABLE) begin
      en_q <= 1'b1;
    end
  end

  // Engine sequencer: walk the memories (an EEPROM byte write skips the walk), then hold busy until the fixed time, counted from the start, runs out.
  wire walk_end = ((op_q == OP_ERASE) & (walk_q == FLASH_LAST)) |
                  ((op_q == OP_FLASH) & (walk_q == COPY_LAST)) |
                  ((op_q == OP_EEP_PAGE) & (walk_q == EEP_PG_LAST));

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      state_q <= ST_IDLE;
      op_q <= OP_ERASE;
      walk_q <= '0;
      cnt_q <= '0;
      page_q <= '0;
      eaddr_q <= '0;
    end else begin
      if (cnt_q != '0) begin
        cnt_q <= cnt_q - CNT_W'(1);
      end
      case (state_q)
        ST_IDLE: begin
          walk_q <= '0;
          if (start_erase) begin
            state_q <= ST_WALK;
            op_q <= OP_ERASE;
            cnt_q <= CNT_W'(ERASE_WAIT_CYC);
          end else if (start_flash) begin
            state_q <= ST_WALK;
            op_q <= OP_FLASH;
            page_q <= pg_field[PAGE_W-1:0];
            cnt_q <= CNT_W'(FLASH_WAIT_CYC);
          end else if (start_eep_byte) begin
            state_q <= ST_WAIT;
            op_q <= OP_EEP_BYTE;
            eaddr_q <= w_eaddr;
            cnt_q <= CNT_W'(EEP_WAIT_CYC);
          end else if (start_eep_page) begin
            state_q <= ST_WALK;
            op_q <= OP_EEP_PAGE;
            eaddr_q <= w_eaddr;
            cnt_q <= CNT_W'(EEP_WAIT_CYC);
          end
        end
        ST_WALK: begin
          walk_q <= walk_q + FLASH_BYTE_W'(1);
          if (walk_end) begin
            state_q <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (cnt_q == '0) begin
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Lock bits only move toward programmed; a chip erase restores them.
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      lock_q <= LOCK_RESET;
    end else if (start_erase) begin
      lock_q <= LOCK_RESET;
    end else if (write_lock) begin
      lock_q <= lock_q & w.b4[5:0];
    end
  end

  // EEPROM page buffer; only loaded bytes are programmed by a page write.
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      epmask_q <= '0;
      for (int k = 0; k < 2**EEP_PAGE_W; k++) begin
        epbuf_q[k] <= ERASED_BYTE;
      end
    end else if (load_eep) begin
      epbuf_q[w.b3[7:6]] <= w.b4;
      epmask_q[w.b3[7:6]] <= 1'b1;
    end else if (walking && op_q == OP_EEP_PAGE && walk_end) begin
      epmask_q <= '0;
    end
  end

  assign miso = miso_q;
  assign miso_oe = prog_mode;
  assign prog_enabled = en_q;
  assign ready_busy_flag = busy;

endmodule

// file: spi_prog_core_checker.sv
// Port assertions and covers for the serial programming engine.
`timescale 1ns/1ps
module spi_prog_core_checker #(
  parameter int FLASH_WAIT_CYC = 200,
  parameter int EEP_WAIT_CYC = 200
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic prog_reset_n,
  input wire logic sck,
  input wire logic mosi,
  input wire logic miso,
  input wire logic miso_oe,
  input wire logic prog_enabled,
  input wire logic ready_busy_flag
);
  localparam int MIN_BUSY = (FLASH_WAIT_CYC < EEP_WAIT_CYC) ? FLASH_WAIT_CYC : EEP_WAIT_CYC;
  logic [31:0] busy_len_q;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // Busy time is counted here because it is far too long for a repetition.
  always_ff @(posedge clk_sys) begin
    if (!nrst || !ready_busy_flag) begin
      busy_len_q <= '0;
    end else begin
      busy_len_q <= busy_len_q + 32'h1;
    end
  end
  a_oe_when_low: assert property (!prog_reset_n [*8] |-> miso_oe)
    else $error("miso not driven in programming mode");
  a_off_when_high: assert property (prog_reset_n [*8] |-> !miso_oe && !prog_enabled)
    else $error("programming active with reset pin high");
  a_enable_in_mode: assert property ($rose(prog_enabled) |-> miso_oe)
    else $error("enable outside programming mode");
  a_drop_on_pulse: assert property ($fell(prog_enabled) |-> $past(prog_reset_n, 3))
    else $error("enable lost without reset pulse");
  a_busy_needs_en: assert property ($rose(ready_busy_flag) |-> prog_enabled)
    else $error("busy started before enable");
  a_busy_at_rise: assert property ($rose(ready_busy_flag) |-> sck)
    else $error("busy started away from a clock rise");
  a_miso_on_fall: assert property ($changed(miso) && !prog_reset_n && $past(!prog_reset_n)
    |-> !sck && $past(!sck, 2))
    else $error("miso changed away from a clock fall");
  a_busy_min_len: assert property ($fell(ready_busy_flag) |-> busy_len_q >= MIN_BUSY)
    else $error("busy ended too early");
  c_enabled: cover property ($rose(prog_enabled));
  c_busy_done: cover property ($fell(ready_busy_flag));
  c_resync: cover property ($fell(prog_enabled));
endmodule

bind spi_prog_core spi_prog_core_checker #(
  .FLASH_WAIT_CYC(FLASH_WAIT_CYC),
  .EEP_WAIT_CYC(EEP_WAIT_CYC)
) chk (
  .clk_sys(clk_sys),
  .nrst(nrst),
  .prog_reset_n(prog_reset_n),
  .sck(sck),
  .mosi(mosi),
  .miso(miso),
  .miso_oe(miso_oe),
  .prog_enabled(prog_enabled),
  .ready_busy_flag(ready_busy_flag)
);

// file: spi_prog_master_model.sv
// Behavioural in-system programmer that drives the serial link.
`timescale 1ns/1ps
module spi_prog_master_model (
  input wire logic clk_sys,
  input wire logic miso,
  input wire logic miso_oe,
  output logic sck,
  output logic mosi,
  output logic rx_stb,
  output logic [31:0] rx_q
);
  import spi_prog_pkg::*;
  localparam int HALF = 8;
  logic line_last_q;
  logic miso_line;
  // A released line toggles so that a stale level can never pass for data.
  assign miso_line = miso_oe ? miso : ~line_last_q;
  initial begin
    sck = 1'b0;
    mosi = 1'b0;
    rx_stb = 1'b0;
    rx_q = '0;
    line_last_q = 1'b0;
  end
  always @(posedge clk_sys) begin
    line_last_q <= miso_line;
  end
  task automatic xfer(input instr_t ins, output logic [31:0] rx);
    logic [31:0] bits;
    bits = ins;
    rx = '0;
    for (int i = 31; i >= 0; i--) begin
      mosi <= bits[i];
      repeat (HALF) @(posedge clk_sys);
      sck <= 1'b1;
      rx = {rx[30:0], miso_line};
      repeat (HALF) @(posedge clk_sys);
      sck <= 1'b0;
    end
    mosi <= ~bits[0];
    rx_q <= rx;
    rx_stb <= 1'b1;
    @(posedge clk_sys);
    rx_stb <= 1'b0;
  endtask
endmodule

// file: spi_prog_pkg.sv
// Constants, types and opcode decoding shared by the serial programming logic.
package spi_prog_pkg;

  localparam real CLK_MHZ = 200.0;
  localparam real FLASH_WRITE_WAIT_MS = 4.5;
  localparam real EEPROM_WRITE_WAIT_MS = 3.6;
  localparam real ERASE_WAIT_MS = 9.0;
  // Busy times must not outlast the programmer's fixed waits, so they round down.
  localparam int FLASH_WRITE_WAIT_CYC = $rtoi(FLASH_WRITE_WAIT_MS * 1000.0 * CLK_MHZ);
  localparam int EEPROM_WRITE_WAIT_CYC = $rtoi(EEPROM_WRITE_WAIT_MS * 1000.0 * CLK_MHZ);
  localparam int ERASE_WAIT_CYC = $rtoi(ERASE_WAIT_MS * 1000.0 * CLK_MHZ);

  localparam logic [7:0] OPC_ENABLE_B1 = 8'hAC;
  localparam logic [7:0] OPC_ENABLE_B2 = 8'h53;
  localparam logic [2:0] OPC_ERASE_B2 = 3'h4;
  localparam logic [2:0] OPC_LOCK_WR_B2 = 3'h7;
  localparam logic [3:0] OPC_FLASH_RD_HI = 4'h2;
  localparam logic [3:0] OPC_FLASH_LD_HI = 4'h4;
  localparam logic [7:0] OPC_FLASH_WR = 8'h4C;
  localparam logic [7:0] OPC_EEP_RD = 8'hA0;
  localparam logic [7:0] OPC_EEP_WR = 8'hC0;
  localparam logic [7:0] OPC_EEP_LD = 8'hC1;
  localparam logic [7:0] OPC_EEP_PG = 8'hC2;
  localparam logic [7:0] OPC_LOCK_RD = 8'h58;
  localparam logic [7:0] OPC_POLL = 8'hF0;

  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic [5:0] LOCK_RESET = 6'h3F;
  localparam logic [1:0] LOCK_READ_PAD = 2'h3;
  localparam logic [2:0] PIN_FILT_RESET = 3'h4;
  localparam logic [4:0] BIT_ECHO = 5'h0F;
  localparam logic [4:0] BIT_ADDR = 5'h17;
  localparam logic [4:0] BIT_LAST = 5'h1F;
  localparam int PAGE_WORD_W = 6;
  localparam int EEP_PAGE_W = 2;

  typedef struct packed {
    logic [7:0] b1;
    logic [7:0] b2;
    logic [7:0] b3;
    logic [7:0] b4;
  } instr_t;

  typedef enum {
    CMD_NONE, CMD_ENABLE, CMD_ERASE, CMD_LOCK_WR, CMD_LOCK_RD, CMD_POLL,
    CMD_FLASH_RD, CMD_FLASH_LD, CMD_FLASH_WR, CMD_EEP_RD, CMD_EEP_WR,
    CMD_EEP_LD, CMD_EEP_PG
  } cmd_t;

  typedef enum {OP_ERASE, OP_FLASH, OP_EEP_BYTE, OP_EEP_PAGE} op_t;
  typedef enum {ST_IDLE, ST_WALK, ST_WAIT} state_t;

  function automatic cmd_t decode_cmd(input logic [7:0] b1, input logic [7:0] b2);
    cmd_t c;
    c = CMD_NONE;
    if (b1 == OPC_ENABLE_B1 && b2 == OPC_ENABLE_B2) begin
      c = CMD_ENABLE;
    end else if (b1 == OPC_ENABLE_B1 && b2[7:5] == OPC_ERASE_B2) begin
      c = CMD_ERASE;
    end else if (b1 == OPC_ENABLE_B1 && b2[7:5] == OPC_LOCK_WR_B2) begin
      c = CMD_LOCK_WR;
    end else if (b1 == OPC_FLASH_WR) begin
      c = CMD_FLASH_WR;
    end else if (b1[7:4] == OPC_FLASH_RD_HI && b1[2:0] == 3'h0) begin
      c = CMD_FLASH_RD;
    end else if (b1[7:4] == OPC_FLASH_LD_HI && b1[2:0] == 3'h0) begin
      c = CMD_FLASH_LD;
    end else if (b1 == OPC_EEP_RD) begin
      c = CMD_EEP_RD;
    end else if (b1 == OPC_EEP_WR) begin
      c = CMD_EEP_WR;
    end else if (b1 == OPC_EEP_LD) begin
      c = CMD_EEP_LD;
    end else if (b1 == OPC_EEP_PG) begin
      c = CMD_EEP_PG;
    end else if (b1 == OPC_LOCK_RD) begin
      c = CMD_LOCK_RD;
    end else if (b1 == OPC_POLL) begin
      c = CMD_POLL;
    end
    return c;
  endfunction

endpackage

// file: test_spi_prog_core.sv
// Self-checking bench for the serial programming engine.
`timescale 1ns/1ps
module test_spi_prog_core;
  import spi_prog_pkg::*;
  typedef struct packed {logic [31:0] mask; logic [31:0] val;} exp_t;
  logic clk_sys, nrst, prog_reset_n, sck, mosi, miso, miso_oe;
  logic prog_enabled, ready_busy_flag, rx_stb;
  logic [31:0] rx_q, rx;
  exp_t exp_q[$];
  int n_fail, n_compared;
  logic [7:0] d [4];
  logic [5:0] pg, w;
  logic [8:0] ea;
  spi_prog_core #(.FLASH_WAIT_CYC(2000), .EEP_WAIT_CYC(2000), .ERASE_WAIT_CYC(9000)) uut (
    .clk_sys(clk_sys), .nrst(nrst), .prog_reset_n(prog_reset_n), .sck(sck), .mosi(mosi),
    .miso(miso), .miso_oe(miso_oe), .prog_enabled(prog_enabled),
    .ready_busy_flag(ready_busy_flag));
  spi_prog_master_model prog (.clk_sys(clk_sys), .miso(miso), .miso_oe(miso_oe), .sck(sck),
    .mosi(mosi), .rx_stb(rx_stb), .rx_q(rx_q));
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  task automatic check(input logic [31:0] got, input logic [31:0] want);
    n_compared++;
    if (got !== want) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask
  task automatic report_and_stop();
    $display("compared=%0d failed=%0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic send(input instr_t ins, input logic [31:0] mask, input logic [31:0] val);
    // Every instruction echoes its second byte while the third is shifted in.
    exp_q.push_back('{mask | 32'h0000FF00, (val & 32'hFFFF00FF) | {16'h0, ins.b2, 8'h00}});
    prog.xfer(ins, rx);
  endtask
  // Polling is bounded so that a busy flag stuck high ends the run.
  task automatic wait_ready();
    for (int i = 0; i < 40; i++) begin
      send({OPC_POLL, 24'h0}, 32'hFE, 32'h0);
      if (rx[0] === 1'b0) return;
    end
    n_fail++;
    report_and_stop();
  endtask
  always @(posedge clk_sys) begin
    if (rx_stb) begin
      exp_t e;
      e = exp_q.pop_front();
      check(rx_q & e.mask, e.val);
    end
  end
  initial begin
    nrst = 1'b0;
    prog_reset_n = 1'b1;
    n_fail = 0;
    n_compared = 0;
    void'($urandom(32'hD95CF296));
    repeat (6) @(posedge clk_sys);
    nrst <= 1'b1;
    prog_reset_n <= 1'b0;
    repeat (20) @(posedge clk_sys);
    ea = 9'($urandom);
    send({OPC_EEP_WR, 7'h0, ea, 8'h3C}, 32'h0000FF00, 32'h0);
    check({31'h0, ready_busy_flag}, 32'h0);
    send({OPC_ENABLE_B1, OPC_ENABLE_B2, 16'($urandom)}, 32'hFF00, 32'h5300);
    check({31'h0, prog_enabled}, 32'h1);
    send({OPC_ENABLE_B1, 3'h4, 5'($urandom), 16'h0}, 32'h0, 32'h0);
    wait_ready();
    send({OPC_EEP_RD, 7'h0, ea, 8'h00}, 32'hFF, 32'hFF);
    send({OPC_FLASH_RD_HI, 1'b1, 3'h0, 8'h0, 8'($urandom), 8'h0}, 32'hFF, 32'hFF);
    send({OPC_LOCK_RD, 24'h0}, 32'hFF, 32'hFF);
    // The second pass rewrites a used location without any erase.
    for (int k = 0; k < 2; k++) begin
      d[0] = 8'($urandom_range(254));
      send({OPC_EEP_WR, 7'h0, ea, d[0]}, 32'h0, 32'h0);
      send({OPC_EEP_RD, 7'h0, ea, 8'h00}, 32'hFF, 32'hFF);
      send({OPC_POLL, 24'h0}, 32'hFF, 32'h01);
      wait_ready();
      send({OPC_EEP_RD, 7'h0, ea, 8'h00}, 32'hFF, {24'h0, d[0]});
    end
    pg = 6'($urandom);
    w = 6'($urandom);
    for (int h = 0; h < 2; h++) begin
      d[h] = 8'($urandom_range(254));
      send({OPC_FLASH_LD_HI, 1'(h), 3'h0, 8'h0, 2'b00, w, d[h]}, 32'h0, 32'h0);
    end
    send({OPC_FLASH_WR, 4'h0, pg, 6'h0, 8'h0}, 32'h0, 32'h0);
    send({OPC_FLASH_RD_HI, 1'b0, 3'h0, 4'h0, pg, w, 8'h0}, 32'hFF, 32'hFF);
    wait_ready();
    for (int h = 0; h < 2; h++) begin
      send({OPC_FLASH_RD_HI, 1'(h), 3'h0, 4'h0, pg, w, 8'h0}, 32'hFF, {24'h0, d[h]});
    end
    for (int i = 0; i < 4; i++) begin
      d[i] = 8'($urandom_range(254));
      send({OPC_EEP_LD, 8'h00, 2'(i), 6'h0, d[i]}, 32'h0, 32'h0);
    end
    send({OPC_EEP_PG, 7'h0, ea[8:2], 2'b00, 8'h0}, 32'h0, 32'h0);
    send({OPC_EEP_RD, 7'h0, ea, 8'h00}, 32'hFF, 32'hFF);
    wait_ready();
    for (int i = 0; i < 4; i++) begin
      send({OPC_EEP_RD, 7'h0, ea[8:2], 2'(i), 8'h0}, 32'hFF, {24'h0, d[i]});
    end
    w = 6'($urandom);
    send({OPC_ENABLE_B1, 3'h7, 5'h0, 8'h0, 2'b11, w}, 32'h0, 32'h0);
    wait_ready();
    send({OPC_LOCK_RD, 24'h0}, 32'hFF, {24'h0, 2'b11, w});
    prog_reset_n <= 1'b1;
    repeat (10) @(posedge clk_sys);
    prog_reset_n <= 1'b0;
    repeat (10) @(posedge clk_sys);
    check({31'h0, prog_enabled}, 32'h0);
    send({OPC_EEP_WR, 7'h0, ea, 8'h00}, 32'h0, 32'h0);
    check({31'h0, ready_busy_flag}, 32'h0);
    send({OPC_ENABLE_B1, OPC_ENABLE_B2, 16'h0}, 32'hFF00, 32'h5300);
    send({OPC_EEP_RD, 7'h0, ea, 8'h00}, 32'hFF, {24'h0, d[ea[1:0]]});
    repeat (3) @(posedge clk_sys);
    report_and_stop();
  end
endmodule
